// ==== rtl/charger_control_status_regs.sv ====
// Control and status register bank of the single-cell charger.
// Assumes a same-clock serial bus engine issues one-cycle reads and
// writes, and that analog flags arrive asynchronously.
`timescale 1ns/100ps
`include "charger_defines.svh"
module charger_control_status_regs #(
  parameter int SWITCH_OFF_DELAY_CYCLES = `SWITCH_OFF_DELAY_CYCLES,
  parameter logic [6:0] DEVICE_ID = 7'h2a // Arbitrary identity value
) (
  input wire logic core_clk_in, // Core clock, 50 MHz
  input wire logic rstn_in, // Async reset, active low
  input wire charger_pkg::reg_req_s reg_req_in, // Register access
  output logic [7:0] reg_rdata_out, // Read data, registered
  input wire charger_pkg::analog_status_s analog_in, // Async flags
  input wire logic watchdog_expired_in, // Watchdog expiry pulse
  input wire logic detect_done_in, // Limit detection finished pulse
  input wire logic [4:0] charge_voltage_code_in, // Programmed target
  input wire logic [12:0] input_voltage_limit_mv_in, // Programmed floor
  input wire logic [12:0] battery_mv_in, // Battery voltage, mV
  output logic detect_request_out, // Run limit detection
  output logic safety_timer_half_rate_out, // Slow safety timer
  output logic registers_restore_out, // Restore pulse, timer reset
  output logic battery_switch_on_out, // Battery switch allowed on
  output logic battery_switch_reset_en_out, // Switch reset enabled
  output logic [4:0] charge_voltage_code_out, // Effective target
  output logic [12:0] input_voltage_limit_eff_out, // Effective floor
  output logic irq_pulse_out // Interrupt pulse toward host
);
  generate
    if (SWITCH_OFF_DELAY_CYCLES < 1) begin : g_bad_delay
      $error("SWITCH_OFF_DELAY_CYCLES must be at least 1");
    end
  endgenerate

  localparam int AW = $bits(charger_pkg::analog_status_s);
  localparam charger_pkg::misc_ctrl_s CTRL_RESET =
    charger_pkg::misc_ctrl_s'(`MISC_CTRL_RESET);

  // Two-stage synchroniser; only the second stage is read
  logic [AW-1:0] sync_meta;
  logic [AW-1:0] sync_out;
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_meta <= '0;
      sync_out <= '0;
    end else begin
      sync_meta <= analog_in;
      sync_out <= sync_meta;
    end
  end
  charger_pkg::analog_status_s st;
  assign st = charger_pkg::analog_status_s'(sync_out);

  // Bus decode
  wire wr_misc = reg_req_in.wr && (reg_req_in.addr == `MISC_CTRL_ADDR);
  wire wr_live = reg_req_in.wr && (reg_req_in.addr == `LIVE_STATUS_ADDR);
  wire wr_reset = reg_req_in.wr && (reg_req_in.addr == `RESET_ID_ADDR);
  wire rd_fault = reg_req_in.rd && (reg_req_in.addr == `FAULT_STATUS_ADDR);
  wire restore_req = wr_reset && reg_req_in.wdata[`RESTORE_BIT];
  wire detect_set = wr_misc && reg_req_in.wdata[7];

  charger_pkg::misc_ctrl_s ctrl;
  charger_pkg::misc_ctrl_s next_ctrl;
  logic [1:0] irq_masks;
  logic [1:0] next_irq_masks;
  logic wdt_flag;
  logic next_wdt_flag;
  logic restore_pulse;

  always_comb begin
    next_ctrl = ctrl;
    if (restore_req) begin
      next_ctrl = CTRL_RESET; // RULE_23
    end else begin
      if (watchdog_expired_in) begin
        // Switch-off, delay and tracking survive the watchdog
        next_ctrl = charger_pkg::misc_ctrl_s'((ctrl & ~`MISC_CTRL_WDT_MASK)
          | (`MISC_CTRL_RESET & `MISC_CTRL_WDT_MASK)); // RULE_25
      end
      if (wr_misc) begin
        next_ctrl = charger_pkg::misc_ctrl_s'(reg_req_in.wdata);
      end
      // A fresh software request wins over a finishing detection
      if (detect_done_in && !detect_set) begin
        next_ctrl.detect = 1'b0; // RULE_01
      end
    end
  end

  always_comb begin
    next_irq_masks = irq_masks;
    if (restore_req) begin
      next_irq_masks = `IRQ_MASKS_RESET; // RULE_23
    end else if (wr_live) begin
      next_irq_masks = reg_req_in.wdata[1:0];
    end
  end

  // Expiry beats a simultaneous clearing read
  assign next_wdt_flag = watchdog_expired_in ? 1'b1 :
    (rd_fault ? 1'b0 : wdt_flag); // RULE_12

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= CTRL_RESET;
      irq_masks <= `IRQ_MASKS_RESET;
      wdt_flag <= 1'b0;
      restore_pulse <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      irq_masks <= next_irq_masks;
      wdt_flag <= next_wdt_flag;
      restore_pulse <= restore_req; // RULE_23
    end
  end
  assign registers_restore_out = restore_pulse;

  // Status field encoding from synchronised flags
  charger_pkg::source_type_e source_type;
  charger_pkg::charge_phase_e charge_phase;
  charger_pkg::fault_code_e fault_code;
  charger_pkg::temp_zone_e temp_zone;

  assign source_type = st.otg_mode ? charger_pkg::SRC_OTG :
    !st.input_present ? charger_pkg::SRC_NONE :
    st.source_select_pin ? charger_pkg::SRC_HOST :
    charger_pkg::SRC_ADAPTER; // RULE_07

  assign charge_phase = !st.charge_enabled ? charger_pkg::PHASE_OFF :
    st.terminated ? charger_pkg::PHASE_DONE :
    st.below_low ? charger_pkg::PHASE_PRE :
    charger_pkg::PHASE_FAST; // RULE_08

  assign fault_code = st.input_fault ? charger_pkg::FAULT_INPUT :
    st.thermal_shutdown ? charger_pkg::FAULT_THERMAL :
    st.timer_expired ? charger_pkg::FAULT_TIMER :
    charger_pkg::FAULT_NONE; // RULE_14

  // Cool zone only exists while bucking, never in OTG
  assign temp_zone = st.hot ? charger_pkg::ZONE_HOT :
    st.cold ? charger_pkg::ZONE_COLD :
    st.warm ? charger_pkg::ZONE_WARM :
    (st.cool && !st.otg_mode) ? charger_pkg::ZONE_COOL :
    charger_pkg::ZONE_NORMAL; // RULE_16

  wire [7:0] misc_word = ctrl;
  wire [7:0] charge_word = {source_type, charge_phase, st.power_good,
    st.thermal_reg, st.min_sys}; // RULE_09 RULE_10 RULE_11
  wire [7:0] fault_word = {wdt_flag, st.boost_fault, fault_code,
    st.bat_ovp, temp_zone}; // RULE_13 RULE_15
  wire [7:0] live_word = {st.good_input, st.vlimit, st.ilimit, 1'b0,
    st.topoff, st.adapter_overvoltage, irq_masks}; // RULE_17 RULE_18 RULE_19 RULE_20
  wire [7:0] reset_word = {restore_pulse, DEVICE_ID};

  logic [7:0] read_word;
  always_comb begin
    unique case (reg_req_in.addr)
      `MISC_CTRL_ADDR: read_word = misc_word;
      `CHARGE_STATUS_ADDR: read_word = charge_word;
      `FAULT_STATUS_ADDR: read_word = fault_word;
      `LIVE_STATUS_ADDR: read_word = live_word;
      `RESET_ID_ADDR: read_word = reset_word;
      default: read_word = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_req_in.rd) begin
      reg_rdata_out <= read_word;
    end
  end

  // Control outputs
  wire cool_zone = (temp_zone == charger_pkg::ZONE_COOL);
  wire in_dpm = st.vlimit || st.ilimit;
  assign detect_request_out = ctrl.detect && st.input_present; // RULE_01
  assign safety_timer_half_rate_out = ctrl.slow_timer &&
    (in_dpm || cool_zone || st.thermal_reg); // RULE_02
  assign battery_switch_reset_en_out = ctrl.sw_rst_en; // RULE_05

  logic [12:0] floor_offset;
  always_comb begin
    unique case (ctrl.track)
      2'h0: floor_offset = 13'h0000;
      2'h1: floor_offset = `VFLOOR_OFS_200;
      2'h2: floor_offset = `VFLOOR_OFS_250;
      2'h3: floor_offset = `VFLOOR_OFS_300;
    endcase
  end
  // Saturate rather than wrap near the top of the range
  wire [13:0] tracked_sum = {1'b0, battery_mv_in} + {1'b0, floor_offset};
  wire [12:0] tracked_mv = tracked_sum[13] ? 13'h1fff : tracked_sum[12:0];
  wire [12:0] next_floor = (ctrl.track != 2'h0 &&
    tracked_mv > input_voltage_limit_mv_in) ?
    tracked_mv : input_voltage_limit_mv_in; // RULE_06

  wire warm_cap = (temp_zone == charger_pkg::ZONE_WARM) && !ctrl.warm_sel;
  wire [4:0] next_voltage_code = (warm_cap &&
    charge_voltage_code_in > `WARM_LIMIT_CODE) ?
    `WARM_LIMIT_CODE : charge_voltage_code_in; // RULE_04

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      input_voltage_limit_eff_out <= 13'h0000;
      charge_voltage_code_out <= 5'h00;
    end else begin
      input_voltage_limit_eff_out <= next_floor;
      charge_voltage_code_out <= next_voltage_code;
    end
  end

  switch_off_timer #(
    .DELAY_CYCLES(SWITCH_OFF_DELAY_CYCLES)
  ) u_switch (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .off_req_in(ctrl.sw_off),
    .delay_en_in(ctrl.sw_dly),
    .switch_on_out(battery_switch_on_out)
  );

  irq_pulse_gen u_irq (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .vlimit_in(st.vlimit),
    .ilimit_in(st.ilimit),
    .vmask_in(irq_masks[1]),
    .imask_in(irq_masks[0]),
    .irq_pulse_out(irq_pulse_out)
  );

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence restore_write_s;
    wr_reset && reg_req_in.wdata[`RESTORE_BIT];
  endsequence
  sequence restore_done_s;
    (ctrl == CTRL_RESET) && (irq_masks == `IRQ_MASKS_RESET)
      && restore_pulse ##1 !restore_pulse;
  endsequence

  restore_defaults_a: assert property ( // RULE_23
    restore_write_s ##1 !restore_req |-> restore_done_s)
    else $error("restore did not reset controls or self-clear");
  detect_clear_a: assert property ( // RULE_01
    detect_done_in && !restore_req && !detect_set |=> !ctrl.detect)
    else $error("detect bit not cleared after detection done");
  detect_hold_a: assert property ( // RULE_01
    detect_set && !restore_req |=> ctrl.detect)
    else $error("detect request lost");
  half_rate_a: assert property ( // RULE_02
    ctrl.slow_timer && st.thermal_reg |-> safety_timer_half_rate_out)
    else $error("safety timer not slowed in thermal regulation");
  wdt_keep_a: assert property ( // RULE_25
    watchdog_expired_in && !wr_misc && !restore_req
    |=> $stable(ctrl.sw_off) && $stable(ctrl.track)
      && ctrl.slow_timer == CTRL_RESET.slow_timer)
    else $error("watchdog restore touched wrong control bits");
  wdt_flag_a: assert property ( // RULE_12
    watchdog_expired_in |=> wdt_flag [*1] ##0 fault_word[7])
    else $error("watchdog flag not set after expiry");
  vfloor_a: assert property ( // RULE_06
    1'b1 |=> input_voltage_limit_eff_out >= $past(input_voltage_limit_mv_in))
    else $error("effective voltage floor below programmed limit");
  warm_cap_a: assert property ( // RULE_04
    warm_cap |=> charge_voltage_code_out <= `WARM_LIMIT_CODE)
    else $error("warm zone voltage not capped");
  source_otg_a: assert property ( // RULE_07
    st.otg_mode |-> charge_word[7:5] == 3'h7)
    else $error("OTG not reported as source type");
  switch_delay_a: assert property ( // RULE_03
    $rose(ctrl.sw_off) && ctrl.sw_dly && SWITCH_OFF_DELAY_CYCLES > 2
    |=> battery_switch_on_out)
    else $error("delayed switch-off happened too early");

  detect_gate_a: assert property ( // RULE_01
    !st.input_present |-> !detect_request_out)
    else $error("detection requested without input");

  reset_en_a: assert property ( // RULE_05
    wr_misc && !restore_req
    |=> battery_switch_reset_en_out == $past(reg_req_in.wdata[2]))
    else $error("switch reset enable not taken");

  source_none_a: assert property ( // RULE_07
    !st.otg_mode && !st.input_present |-> charge_word[7:5] == 3'h0)
    else $error("missing input not reported");

  phase_off_a: assert property ( // RULE_08
    !st.charge_enabled |-> charge_word[4:3] == 2'h0)
    else $error("phase not off while disabled");

  phase_done_a: assert property ( // RULE_08
    st.charge_enabled && st.terminated |-> charge_word[4:3] == 2'h3)
    else $error("termination not reported");

  charge_read_a: assert property ( // RULE_09 RULE_10 RULE_11
    reg_req_in.rd && reg_req_in.addr == `CHARGE_STATUS_ADDR
    |=> reg_rdata_out[2] == $past(st.power_good)
      && reg_rdata_out[1] == $past(st.thermal_reg)
      && reg_rdata_out[0] == $past(st.min_sys))
    else $error("charge status read wrong");

  fault_input_a: assert property ( // RULE_14
    st.input_fault |-> fault_word[5:4] == 2'h1)
    else $error("input fault not reported");

  fault_timer_a: assert property ( // RULE_14
    !st.input_fault && !st.thermal_shutdown && st.timer_expired
    |-> fault_word[5:4] == 2'h3)
    else $error("timer expiry not reported");

  fault_read_a: assert property ( // RULE_13 RULE_15
    rd_fault |=> reg_rdata_out[6] == $past(st.boost_fault)
      && reg_rdata_out[3] == $past(st.bat_ovp))
    else $error("fault flags read wrong");

  zone_hot_a: assert property ( // RULE_16
    st.hot |-> fault_word[2:0] == 3'h6)
    else $error("hot zone not reported");

  zone_cool_a: assert property ( // RULE_16
    st.cool && !st.otg_mode && !st.hot && !st.cold && !st.warm
    |-> fault_word[2:0] == 3'h3)
    else $error("cool zone not reported");

  live_read_a: assert property ( // RULE_17 RULE_18 RULE_19 RULE_20
    reg_req_in.rd && reg_req_in.addr == `LIVE_STATUS_ADDR
    |=> reg_rdata_out[7] == $past(st.good_input)
      && reg_rdata_out[6:5] == {$past(st.vlimit), $past(st.ilimit)}
      && reg_rdata_out[3:2] == {$past(st.topoff), $past(st.adapter_overvoltage)})
    else $error("live status read wrong");

  masks_write_a: assert property ( // RULE_21 RULE_22
    wr_live && !restore_req
    |=> irq_masks == $past(reg_req_in.wdata[1:0]))
    else $error("interrupt masks not taken");

  wdt_clear_a: assert property ( // RULE_12
    rd_fault && !watchdog_expired_in |=> !wdt_flag)
    else $error("watchdog flag not cleared by read");
endmodule

// ==== rtl/charger_defines.svh ====
// Constants for the charger control and status register bank.
// Assumes one 50 MHz core clock and byte-wide registers.
//
// Functional notes
// [RULE_01] Forced limit detection runs, bit clears when done
// [RULE_02] Safety timer half rate in limit, cool, thermal
// [RULE_03] Switch off now or after delay; clear allows on
// [RULE_04] Warm zone caps voltage unless selector set
// [RULE_05] Switch reset function follows its enable bit
// [RULE_06] Voltage floor is max of limit, battery+offset
// [RULE_07] Source type codes none, host, adapter, OTG
// [RULE_08] Charge phase codes off, pre, fast, done
// [RULE_09] Power good bit follows input supply quality
// [RULE_10] Thermal regulation bit follows die regulation
// [RULE_11] Minimum system voltage bit follows battery level
// [RULE_12] Watchdog flag reads one after expiry
// [RULE_13] Boost fault bit follows boost start blockers
// [RULE_14] Fault code normal, input, thermal, safety timer
// [RULE_15] Battery overvoltage flag follows detector
// [RULE_16] Temperature zone code tracks thermistor live
// [RULE_17] Good input bit follows attached supply
// [RULE_18] Limit loop bits follow loops in control
// [RULE_19] Top-off bit follows extension timer counting
// [RULE_20] Input overvoltage flag follows adapter detector
// [RULE_21] Voltage limit mask suppresses its pulse
// [RULE_22] Current limit mask suppresses its pulse
// [RULE_23] Restore bit resets controls and timer, self-clears
// [RULE_24] Host refreshes watchdog before its expiry
// [RULE_25] Watchdog restores only watchdog-marked control bits
// [RULE_26] Unmasked limit entry gives one interrupt pulse
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

`define MISC_CTRL_ADDR 8'h07
`define CHARGE_STATUS_ADDR 8'h08
`define FAULT_STATUS_ADDR 8'h09
`define LIVE_STATUS_ADDR 8'h0a
`define RESET_ID_ADDR 8'h0b

`define RESTORE_BIT 7
`define MISC_CTRL_RESET 8'h4c
`define MISC_CTRL_WDT_MASK 8'hd4
`define IRQ_MASKS_RESET 2'h0

`define VFLOOR_OFS_200 13'h00c8
`define VFLOOR_OFS_250 13'h00fa
`define VFLOOR_OFS_300 13'h012c
`define WARM_LIMIT_CODE 5'h07

`define CLK_HZ 50000000
`define SWITCH_OFF_DELAY_S 8
`define SWITCH_OFF_DELAY_CYCLES (`SWITCH_OFF_DELAY_S * `CLK_HZ)

`endif

// ==== rtl/charger_pkg.sv ====
// Types shared by the charger register bank and its helpers.
// Assumes the defines header supplies all numeric constants.
package charger_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic detect;
    logic slow_timer;
    logic sw_off;
    logic warm_sel;
    logic sw_dly;
    logic sw_rst_en;
    logic [1:0] track;
  } misc_ctrl_s;

  // Raw flags from the analog side, not yet synchronised
  typedef struct packed {
    logic input_present;
    logic power_good;
    logic good_input;
    logic vlimit;
    logic ilimit;
    logic thermal_reg;
    logic min_sys;
    logic topoff;
    logic adapter_overvoltage;
    logic otg_mode;
    logic source_select_pin;
    logic charge_enabled;
    logic below_low;
    logic terminated;
    logic boost_fault;
    logic input_fault;
    logic thermal_shutdown;
    logic timer_expired;
    logic bat_ovp;
    logic warm;
    logic cool;
    logic cold;
    logic hot;
  } analog_status_s;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_HOST = 3'h1, SRC_ADAPTER = 3'h2, SRC_OTG = 3'h7
  } source_type_e;

  typedef enum logic [1:0] {
    PHASE_OFF = 2'h0, PHASE_PRE = 2'h1, PHASE_FAST = 2'h2, PHASE_DONE = 2'h3
  } charge_phase_e;

  typedef enum logic [1:0] {
    FAULT_NONE = 2'h0, FAULT_INPUT = 2'h1, FAULT_THERMAL = 2'h2,
    FAULT_TIMER = 2'h3
  } fault_code_e;

  typedef enum logic [2:0] {
    ZONE_NORMAL = 3'h0, ZONE_WARM = 3'h2, ZONE_COOL = 3'h3,
    ZONE_COLD = 3'h5, ZONE_HOT = 3'h6
  } temp_zone_e;

endpackage

// ==== rtl/irq_pulse_gen.sv ====
// Interrupt pulse on entry into the input limit loops.
// Assumes loop flags are already synchronised to the core clock.
`timescale 1ns/100ps
module irq_pulse_gen (
  input wire logic core_clk_in, // Core clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic vlimit_in, // Voltage limit loop active
  input wire logic ilimit_in, // Current limit loop active
  input wire logic vmask_in, // Voltage limit pulse masked
  input wire logic imask_in, // Current limit pulse masked
  output logic irq_pulse_out // One-cycle interrupt pulse
);
  logic vlimit_d;
  logic ilimit_d;
  wire v_entry = vlimit_in && !vlimit_d && !vmask_in; // RULE_21
  wire i_entry = ilimit_in && !ilimit_d && !imask_in; // RULE_22

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vlimit_d <= 1'b0;
      ilimit_d <= 1'b0;
      irq_pulse_out <= 1'b0;
    end else begin
      vlimit_d <= vlimit_in;
      ilimit_d <= ilimit_in;
      // Entries in back-to-back cycles merge; a pulse never stretches
      irq_pulse_out <= (v_entry || i_entry) && !irq_pulse_out; // RULE_26
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  masked_quiet_a: assert property ( // RULE_21
    vmask_in && imask_in && $past(vmask_in) && $past(imask_in)
    |-> !irq_pulse_out)
    else $error("interrupt pulse while both sources masked");
  pulse_single_a: assert property ( // RULE_26
    irq_pulse_out |=> !irq_pulse_out)
    else $error("interrupt pulse longer than one cycle");
  entry_pulse_a: assert property ( // RULE_26
    ilimit_in && !ilimit_d && !imask_in && !irq_pulse_out |=> irq_pulse_out)
    else $error("unmasked entry gave no pulse");
endmodule

// ==== rtl/switch_off_timer.sv ====
// Battery switch gate with optional turn-off delay.
// Assumes off request and delay select come from same-clock registers.
`timescale 1ns/100ps
`include "charger_defines.svh"
module switch_off_timer #(
  parameter int DELAY_CYCLES = `SWITCH_OFF_DELAY_CYCLES
) (
  input wire logic core_clk_in, // Core clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic off_req_in, // Switch off requested
  input wire logic delay_en_in, // Wait the delay before turning off
  output logic switch_on_out // Battery switch allowed on
);
  generate
    if (DELAY_CYCLES < 1) begin : g_bad
      $error("switch_off_timer: DELAY_CYCLES must be at least 1");
    end
  endgenerate

  logic [31:0] count;
  wire delay_done = (count >= 32'(DELAY_CYCLES - 1));
  wire turn_off = off_req_in && (!delay_en_in || delay_done);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= 32'h0;
      switch_on_out <= 1'b1;
    end else begin
      count <= (off_req_in && !delay_done) ? count + 32'h1 : 32'h0;
      if (!off_req_in) begin
        switch_on_out <= 1'b1; // RULE_03
      end else if (turn_off) begin
        switch_on_out <= 1'b0; // RULE_03
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  immediate_off_a: assert property ( // RULE_03
    off_req_in && !delay_en_in |=> !switch_on_out)
    else $error("switch not off one cycle after immediate request");
  release_on_a: assert property ( // RULE_03
    !off_req_in |=> switch_on_out)
    else $error("switch not allowed on after request cleared");
endmodule

// ==== verif/charger_control_status_regs_bench.sv ====
// Self-checking bench for the charger control and status registers.
// Assumes the host model owns the register port; bench drives the rest.
`timescale 1ns/100ps
`include "charger_defines.svh"
module charger_control_status_regs_bench;
  localparam int DLY = 16;
  localparam logic [6:0] ID = 7'h35; // Arbitrary identity value
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  charger_pkg::reg_req_s req;
  charger_pkg::analog_status_s an = '0;
  logic [7:0] rdata, rd;
  logic wdt = 1'b0;
  logic done = 1'b0;
  logic [4:0] vcode = 5'h0b;
  logic [12:0] vlim = 13'h1194;
  logic [12:0] vbat = 13'h0e10;
  logic det, half, rst_pulse, sw_on, rst_en, irq;
  logic [4:0] vcode_out;
  logic [12:0] floor_out;
  logic [31:0] seed = 32'h1513;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int cnt;

  always #10 core_clk_in = ~core_clk_in;

  charger_host_model charger_host_model_i (.core_clk_in(core_clk_in),
    .rdata_in(rdata), .req_out(req));

  charger_control_status_regs #(.SWITCH_OFF_DELAY_CYCLES(DLY),
    .DEVICE_ID(ID)) charger_control_status_regs_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .analog_in(an), .watchdog_expired_in(wdt),
    .detect_done_in(done), .charge_voltage_code_in(vcode),
    .input_voltage_limit_mv_in(vlim), .battery_mv_in(vbat),
    .detect_request_out(det), .safety_timer_half_rate_out(half),
    .registers_restore_out(rst_pulse), .battery_switch_on_out(sw_on),
    .battery_switch_reset_en_out(rst_en),
    .charge_voltage_code_out(vcode_out),
    .input_voltage_limit_eff_out(floor_out), .irq_pulse_out(irq));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp08(charger_pkg::analog_status_s a);
    logic [2:0] s;
    logic [1:0] p;
    s = a.otg_mode ? 3'h7 : !a.input_present ? 3'h0 :
      a.source_select_pin ? 3'h1 : 3'h2;
    p = !a.charge_enabled ? 2'h0 : a.terminated ? 2'h3 :
      a.below_low ? 2'h1 : 2'h2;
    return {s, p, a.power_good, a.thermal_reg, a.min_sys};
  endfunction

  function automatic logic [7:0] exp09(charger_pkg::analog_status_s a);
    logic [1:0] f;
    logic [2:0] z;
    f = a.input_fault ? 2'h1 : a.thermal_shutdown ? 2'h2 :
      a.timer_expired ? 2'h3 : 2'h0;
    z = a.hot ? 3'h6 : a.cold ? 3'h5 : a.warm ? 3'h2 :
      (a.cool && !a.otg_mode) ? 3'h3 : 3'h0;
    return {1'b0, a.boost_fault, f, a.bat_ovp, z};
  endfunction

  function automatic logic [12:0] exp_floor(logic [1:0] t, logic [12:0] l,
    logic [12:0] b);
    logic [13:0] sum;
    logic [12:0] ofs;
    ofs = t == 2'h1 ? `VFLOOR_OFS_200 : t == 2'h2 ? `VFLOOR_OFS_250 :
      `VFLOOR_OFS_300;
    sum = {1'b0, b} + {1'b0, ofs};
    if (sum > 14'h1fff) sum = 14'h1fff;
    return (t == 2'h0 || l >= sum[12:0]) ? l : sum[12:0];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    charger_host_model_i.write_reg(a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    charger_host_model_i.read_reg(a, rd);
    check({8'h00, rd}, {8'h00, e});
  endtask

  task automatic pulse(input bit w);
    @(posedge core_clk_in);
    if (w) wdt <= 1'b1; else done <= 1'b1;
    @(posedge core_clk_in);
    wdt <= 1'b0;
    done <= 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Random analog and control words; at most one zone flag set, OTG may hide cool
  task automatic status_loop();
    charger_pkg::analog_status_s a;
    logic [31:0] r, q;
    logic [7:0] ctrl;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      q = rnd();
      ctrl = r[7:0] & 8'hdf;
      a = r[31:9];
      {a.warm, a.cool, a.cold, a.hot} = 4'h1 << (q[31:29] % 5);
      @(posedge core_clk_in);
      an <= a;
      vcode <= q[4:0];
      vlim <= q[17:5];
      vbat <= q[30:18];
      wr(8'h07, ctrl);
      wr(8'h0a, {6'h3f, r[9:8]});
      wr(8'h08, 8'hff);
      rchk(8'h08, exp08(a));
      rchk(8'h09, exp09(a));
      rchk(8'h0a, {a.good_input, a.vlimit, a.ilimit, 1'b0, a.topoff,
        a.adapter_overvoltage, r[9:8]});
      check(det, ctrl[7] & a.input_present);
      check(half, ctrl[6] & (a.vlimit | a.ilimit | a.thermal_reg |
        (a.cool & !a.otg_mode)));
      check(vcode_out, (a.warm && !ctrl[4] && q[4:0] > 5'h07) ?
        5'h07 : q[4:0]);
      check(floor_out, exp_floor(ctrl[1:0], q[17:5], q[30:18]));
      check(rst_en, ctrl[2]);
    end
  endtask

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (4) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    rchk(8'h07, `MISC_CTRL_RESET);
    rchk(8'h0a, 8'h00);
    rchk(8'h0b, {1'b0, ID});
    rchk(8'h3c, 8'h00);
    status_loop();
    @(posedge core_clk_in);
    an <= '{input_present: 1'b1, default: 1'b0};
    wr(8'h07, 8'hcc);
    repeat (3) @(negedge core_clk_in);
    check(det, 1'b1);
    pulse(1'b0);
    rchk(8'h07, 8'h4c);
    check(det, 1'b0);
    // Immediate switch off, then allow on, then delayed off
    wr(8'h07, 8'h24);
    repeat (2) @(negedge core_clk_in);
    check(sw_on, 1'b0);
    wr(8'h07, 8'h04);
    repeat (2) @(negedge core_clk_in);
    check(sw_on, 1'b1);
    wr(8'h07, 8'h2c);
    cnt = 0;
    while (sw_on === 1'b1 && cnt < 40) begin
      @(negedge core_clk_in);
      cnt++;
    end
    check(cnt >= DLY - 1 && cnt <= DLY + 2, 1'b1);
    wr(8'h07, 8'hbb);
    @(negedge core_clk_in);
    check(rst_en, 1'b0);
    pulse(1'b1);
    rchk(8'h07, 8'h6f);
    rchk(8'h09, 8'h80);
    rchk(8'h09, 8'h00);
    check(rst_en, 1'b1);
    wr(8'h0a, 8'h03);
    wr(8'h0b, 8'h80);
    @(negedge core_clk_in);
    check(rst_pulse, 1'b1);
    @(negedge core_clk_in);
    check(rst_pulse, 1'b0);
    rchk(8'h07, `MISC_CTRL_RESET);
    rchk(8'h0a, 8'h00);
    rchk(8'h0b, {1'b0, ID});
    check(sw_on, 1'b1);
    // k[1] picks the voltage loop, k[0] masks the loop under test
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk_in);
      an <= '0;
      wr(8'h0a, (k[1] ^ k[0]) ? 8'h01 : 8'h02);
      repeat (4) @(posedge core_clk_in);
      an <= '{vlimit: k[1], ilimit: !k[1], default: 1'b0};
      cnt = 0;
      repeat (8) begin
        @(negedge core_clk_in);
        cnt += irq;
      end
      check(cnt[15:0], !k[0]);
    end
    summarize();
  end
endmodule

// ==== verif/charger_host_model.sv ====
// Host-side model of the register port: single-byte writes and reads.
// Assumes the bank takes a request at the rising edge and answers next.
`timescale 1ns/100ps
module charger_host_model (
  input wire logic core_clk_in, // Core clock
  input wire logic [7:0] rdata_in, // Read data from the bank
  output charger_pkg::reg_req_s req_out // Register request
);
  initial req_out = '0;

  // No watchdog refresh is modelled here; expiry is only forced by the bench
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge core_clk_in);
    req_out <= '0;
  endtask

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge core_clk_in);
    req_out <= '0;
    @(negedge core_clk_in);
    data = rdata_in;
  endtask
endmodule
